// ==== rtl/acx_exec_unit.sv ====
// add-with-carry decode and execution unit with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "acx_params.svh"

module acx_exec_unit #(
  parameter int AXI_ADDR_W = 8
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  inst_valid_i,
  input  wire acx_pkg::acx_inst_t    inst_i,
  output logic                       inst_ready_o,
  output logic                       done_o,
  output acx_pkg::acx_rf_req_t       rf_req_o,
  input  wire logic [7:0]            rf_rdata_i,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i
);

  if (AXI_ADDR_W < 5 || AXI_ADDR_W > 32) begin : g_bad_addr_w
    $error("AXI_ADDR_W must lie between 5 and 32");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  acx_pkg::acx_state_t   state;
  acx_pkg::acx_state_t   next_state;
  acx_pkg::acx_flags_t   flags;
  acx_pkg::acx_flags_t   pend_flags;
  acx_pkg::acx_inst_t    inst_q;
  logic [7:0]            rp;
  logic [3:0]            rp_hi_q;
  logic                  short_q;
  logic [3:0]            cyc;
  logic [3:0]            cyc_total;
  logic [7:0]            src_q;
  logic [7:0]            result_q;
  logic [7:0]            rf_addr;
  logic [7:0]            next_addr;
  logic                  rf_we;
  logic                  bad_op;
  logic [31:0]           done_count;
  logic                  accept;
  logic                  legal;
  logic [8:0]            sum9;
  logic [4:0]            low5;
  logic                  aw_got;
  logic                  w_got;
  logic [3:0]            aw_off;
  logic                  aw_hi_ok;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_do;
  logic [3:0]            ar_off;
  logic                  ar_hi_ok;

  // full-register operand: nibble E maps onto the working group
  function automatic logic [7:0] acx_resolve(input logic [7:0] b,
                                             input logic [3:0] grp);
    acx_resolve = (b[7:4] == `ACX_WREG_NIBBLE) ? {grp, b[3:0]} : b;
  endfunction

  // ---------------------------------------------------------------
  // decode and sequencing
  // ---------------------------------------------------------------
  assign accept       = inst_valid_i && (state == acx_pkg::ACX_IDLE);
  assign inst_ready_o = (state == acx_pkg::ACX_IDLE);
  assign legal        = (inst_i.opcode_byte >= `ACX_OPC_WR_WR) &&
                        (inst_i.opcode_byte <= `ACX_OPC_IR_IM);

  always_comb begin
    next_state = state;
    next_addr  = rf_addr;
    unique case (state)
      acx_pkg::ACX_IDLE: begin
        if (accept && legal) begin
          unique case (inst_i.opcode_byte)
            `ACX_OPC_WR_WR: begin
              next_addr  = {rp[7:4], inst_i.arg1[3:0]};
              next_state = acx_pkg::ACX_SRC;
            end
            `ACX_OPC_WR_IWR: begin
              next_addr  = {rp[7:4], inst_i.arg1[3:0]};
              next_state = acx_pkg::ACX_SRC_PTR;
            end
            `ACX_OPC_R_R: begin
              next_addr  = acx_resolve(inst_i.arg1, rp[7:4]);
              next_state = acx_pkg::ACX_SRC;
            end
            `ACX_OPC_R_IR: begin
              next_addr  = acx_resolve(inst_i.arg1, rp[7:4]);
              next_state = acx_pkg::ACX_SRC_PTR;
            end
            `ACX_OPC_R_IM: begin
              next_addr  = acx_resolve(inst_i.arg1, rp[7:4]);
              next_state = acx_pkg::ACX_DST;
            end
            default: begin
              next_addr  = acx_resolve(inst_i.arg1, rp[7:4]);
              next_state = acx_pkg::ACX_DST_PTR;
            end
          endcase
        end
      end
      acx_pkg::ACX_SRC_PTR: begin
        next_addr  = rf_rdata_i;
        next_state = acx_pkg::ACX_SRC;
      end
      acx_pkg::ACX_SRC: begin
        // source has been fetched; the destination follows it
        if (short_q) begin
          next_addr = {rp_hi_q, inst_q.arg1[7:4]};
        end else begin
          next_addr = acx_resolve(inst_q.arg2, rp_hi_q);
        end
        next_state = acx_pkg::ACX_DST;
      end
      acx_pkg::ACX_DST_PTR: begin
        next_addr  = rf_rdata_i;
        next_state = acx_pkg::ACX_DST;
      end
      acx_pkg::ACX_DST: begin
        next_state = acx_pkg::ACX_WAIT;
      end
      acx_pkg::ACX_WAIT: begin
        // pad out to the fixed instruction length
        if (cyc == cyc_total - `ACX_CYC_WAIT_OFS) begin
          next_state = acx_pkg::ACX_WB;
        end
      end
      acx_pkg::ACX_WB: begin
        next_state = acx_pkg::ACX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= acx_pkg::ACX_IDLE;
      rf_addr <= 8'h00;
      rf_we   <= 1'b0;
    end else begin
      state   <= next_state;
      rf_addr <= next_addr;
      rf_we   <= (next_state == acx_pkg::ACX_WB);
    end
  end

  // instruction latch; the pointer group is frozen for the whole op
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inst_q    <= '0;
      rp_hi_q   <= 4'h0;
      short_q   <= 1'b0;
      cyc_total <= `ACX_CYC_SHORT;
    end else if (accept) begin
      inst_q  <= inst_i;
      rp_hi_q <= rp[7:4];
      short_q <= (inst_i.opcode_byte <= `ACX_OPC_WR_IWR);
      cyc_total <= (inst_i.opcode_byte <= `ACX_OPC_WR_IWR) ?
                   `ACX_CYC_SHORT : `ACX_CYC_LONG;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc <= 4'h0;
    end else if (accept) begin
      cyc <= `ACX_CYC_FIRST;
    end else if (state != acx_pkg::ACX_IDLE) begin
      cyc <= cyc + `ACX_CYC_FIRST;
    end
  end

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  assign sum9 = {1'b0, rf_rdata_i} + {1'b0, src_q} + {8'h00, flags.c};
  assign low5 = {1'b0, rf_rdata_i[3:0]} + {1'b0, src_q[3:0]} +
                {4'h0, flags.c};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q      <= 8'h00;
      result_q   <= 8'h00;
      pend_flags <= `ACX_FLAGS_RST;
    end else begin
      if (accept && (inst_i.opcode_byte >= `ACX_OPC_R_IM)) begin
        src_q <= inst_i.arg2;
      end else if (state == acx_pkg::ACX_SRC) begin
        src_q <= rf_rdata_i;
      end
      if (state == acx_pkg::ACX_DST) begin
        result_q     <= sum9[7:0];
        pend_flags.c <= sum9[8];
        pend_flags.z <= (sum9[7:0] == 8'h00);
        pend_flags.s <= sum9[7];
        pend_flags.v <= (rf_rdata_i[7] == src_q[7]) &&
                        (sum9[7] != rf_rdata_i[7]);
        pend_flags.d <= 1'b0;
        pend_flags.h <= low5[4];
      end
    end
  end

  // only the destination address is ever driven with a write
  assign rf_req_o = '{we: rf_we, addr: rf_addr, wdata: result_q};
  assign done_o   = rf_we;

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_got && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_do           = aw_got && w_got && !s_axi_bvalid_o;
  assign ar_off          = s_axi_araddr_i[3:0];
  assign ar_hi_ok        = (s_axi_araddr_i[AXI_ADDR_W-1:4] == '0);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got   <= 1'b0;
      aw_off   <= 4'h0;
      aw_hi_ok <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got   <= 1'b1;
      aw_off   <= s_axi_awaddr_i[3:0];
      aw_hi_ok <= (s_axi_awaddr_i[AXI_ADDR_W-1:4] == '0);
    end else if (wr_do) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_got   <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got   <= 1'b1;
      wdata_q <= s_axi_wdata_i;
      wstrb_q <= s_axi_wstrb_i;
    end else if (wr_do) begin
      w_got <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `ACX_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (aw_hi_ok && (aw_off[1:0] == 2'h0)) ?
                       `ACX_RESP_OKAY : `ACX_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // register pointer; sampled only when an instruction is taken
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rp <= `ACX_RP_RST;
    end else if (wr_do && aw_hi_ok && (aw_off == `ACX_OFF_CTRL) &&
                 wstrb_q[0]) begin
      rp <= wdata_q[7:0];
    end
  end

  // the commit of an instruction wins over a software write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= `ACX_FLAGS_RST;
    end else if (state == acx_pkg::ACX_WB) begin
      flags <= pend_flags;
    end else if (wr_do && aw_hi_ok && (aw_off == `ACX_OFF_FLAGS) &&
                 wstrb_q[0]) begin
      flags <= wdata_q[5:0];
    end
  end

  // sticky unsupported-opcode bit, write one to clear, set wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bad_op <= 1'b0;
    end else if (accept && !legal) begin
      bad_op <= 1'b1;
    end else if (wr_do && aw_hi_ok && (aw_off == `ACX_OFF_STATUS) &&
                 wstrb_q[0] && wdata_q[`ACX_ST_BAD]) begin
      bad_op <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_count <= 32'h0000_0000;
    end else if (rf_we) begin
      done_count <= done_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `ACX_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `ACX_RESP_OKAY;
      if (!ar_hi_ok) begin
        s_axi_rresp_o <= `ACX_RESP_SLVERR;
      end else begin
        unique case (ar_off)
          `ACX_OFF_CTRL: begin
            s_axi_rdata_o[7:0] <= rp;
          end
          `ACX_OFF_FLAGS: begin
            s_axi_rdata_o[5:0] <= flags;
          end
          `ACX_OFF_STATUS: begin
            s_axi_rdata_o[`ACX_ST_BUSY] <= (state != acx_pkg::ACX_IDLE);
            s_axi_rdata_o[`ACX_ST_BAD]  <= bad_op;
            s_axi_rdata_o[`ACX_ST_RES_MSB:`ACX_ST_RES_LSB] <= result_q;
          end
          `ACX_OFF_COUNT: begin
            s_axi_rdata_o <= done_count;
          end
          default: begin
            s_axi_rresp_o <= `ACX_RESP_SLVERR;
          end
        endcase
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

// ==== rtl/acx_params.svh ====
// named constants of the add-with-carry execution unit
`ifndef ACX_PARAMS_SVH
`define ACX_PARAMS_SVH

// ---------------------------------------------------------------
// opcodes and cycle counts
// ---------------------------------------------------------------
`define ACX_OPC_WR_WR      8'h12
`define ACX_OPC_WR_IWR     8'h13
`define ACX_OPC_R_R        8'h14
`define ACX_OPC_R_IR       8'h15
`define ACX_OPC_R_IM       8'h16
`define ACX_OPC_IR_IM      8'h17
`define ACX_CYC_SHORT      4'h6
`define ACX_CYC_LONG       4'hA
`define ACX_CYC_WAIT_OFS   4'h2
`define ACX_CYC_FIRST      4'h1
`define ACX_WREG_NIBBLE    4'hE

// ---------------------------------------------------------------
// register map, fields and reset values
// ---------------------------------------------------------------
`define ACX_OFF_CTRL       4'h0
`define ACX_OFF_FLAGS      4'h4
`define ACX_OFF_STATUS     4'h8
`define ACX_OFF_COUNT      4'hC
`define ACX_ST_BUSY        0
`define ACX_ST_BAD         1
`define ACX_ST_RES_LSB     8
`define ACX_ST_RES_MSB     15
`define ACX_RP_RST         8'h00
`define ACX_FLAGS_RST      6'h00
`define ACX_RESP_OKAY      2'h0
`define ACX_RESP_SLVERR    2'h2

`endif

// ==== rtl/acx_pkg.sv ====
// types shared by the add-with-carry execution unit
package acx_pkg;

  typedef struct packed {
    logic [7:0] opcode_byte;
    logic [7:0] arg1;
    logic [7:0] arg2;
  } acx_inst_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } acx_flags_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acx_rf_req_t;

  typedef enum logic [2:0] {
    ACX_IDLE,
    ACX_SRC_PTR,
    ACX_SRC,
    ACX_DST_PTR,
    ACX_DST,
    ACX_WAIT,
    ACX_WB
  } acx_state_t;

endpackage

// ==== sim/acx_exec_unit_chk.sv ====
// assertion checker for the add-with-carry execution unit
`timescale 1ns/10ps
module acx_exec_unit_chk (
  input wire logic                 mclk_i,
  input wire logic                 rst_n_i,
  input wire logic                 inst_valid_i,
  input wire acx_pkg::acx_inst_t   inst_i,
  input wire logic                 inst_ready_o,
  input wire logic                 done_o,
  input wire acx_pkg::acx_rf_req_t rf_req_o
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic       take;
  logic       sh;
  logic       lg;
  logic       raw;
  logic [7:0] op;
  assign op = inst_i.opcode_byte;
  assign take = inst_valid_i && inst_ready_o;
  assign sh = take && (op == 8'h12 || op == 8'h13);
  assign lg = take && op >= 8'h14 && op <= 8'h17;
  // working-register bytes need the pointer, so only plain bytes here
  assign raw = inst_i.arg1[7:4] != 4'hE && inst_i.arg2[7:4] != 4'hE;
  property p_short_len; sh |-> ##5 done_o; endproperty
  a_short_len: assert property (p_short_len)
    else $error("short form not done in its sixth cycle");
  property p_short_busy;
    sh |=> !inst_ready_o [*5] ##1 inst_ready_o;
  endproperty
  a_short_busy: assert property (p_short_busy)
    else $error("short form busy window wrong");
  property p_long_len; lg |-> ##9 done_o ##1 inst_ready_o; endproperty
  a_long_len: assert property (p_long_len)
    else $error("long form not done in its tenth cycle");
  property p_src_first;
    take && op == 8'h14 && raw |=> rf_req_o.addr == $past(inst_i.arg1)
      ##1 rf_req_o.addr == $past(inst_i.arg2, 2);
  endproperty
  a_src_first: assert property (p_src_first)
    else $error("source byte not read before destination");
  property p_imm_dst;
    take && op == 8'h16 && raw |=> rf_req_o.addr == $past(inst_i.arg1)
      ##8 done_o && rf_req_o.addr == $past(inst_i.arg1, 9);
  endproperty
  a_imm_dst: assert property (p_imm_dst)
    else $error("immediate form used the wrong destination");
  property p_bad_op;
    take && (op < 8'h12 || op > 8'h17) |=> inst_ready_o && !rf_req_o.we;
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("unknown opcode was executed");
  property p_wb_hold;
    rf_req_o.we |-> done_o && rf_req_o.addr == $past(rf_req_o.addr);
  endproperty
  a_wb_hold: assert property (p_wb_hold)
    else $error("write-back left the destination address");
  property p_one_write; rf_req_o.we |=> !rf_req_o.we [*5]; endproperty
  a_one_write: assert property (p_one_write)
    else $error("more than one write per instruction");
  c_short: cover property (sh ##5 done_o);
  c_long: cover property (lg ##9 done_o);
  c_bad: cover property (take && (op < 8'h12 || op > 8'h17));
endmodule

bind acx_exec_unit acx_exec_unit_chk u_acx_exec_unit_chk (
  .mclk_i      (mclk_i),
  .rst_n_i     (rst_n_i),
  .inst_valid_i(inst_valid_i),
  .inst_i      (inst_i),
  .inst_ready_o(inst_ready_o),
  .done_o      (done_o),
  .rf_req_o    (rf_req_o)
);

// ==== sim/acx_rf_model.sv ====
// register file model on the far side of the execution unit
`timescale 1ns/10ps
module acx_rf_model (
  input  wire logic                 mclk_i,
  input  wire acx_pkg::acx_rf_req_t rf_req_i,
  output logic [7:0]                rf_rdata_o
);
  // plain always so the bench may preload cells between instructions
  logic [7:0] mem [256];
  assign rf_rdata_o = mem[rf_req_i.addr];
  always @(posedge mclk_i) begin
    if (rf_req_i.we) begin
      mem[rf_req_i.addr] <= rf_req_i.wdata;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the add-with-carry execution unit
`timescale 1ns/10ps
module testbench;
  logic                 clk = 1'h0, rst_n = 1'h0, iv = 1'h0;
  logic                 awv = 1'h0, wv = 1'h0, br = 1'h0;
  logic                 arv = 1'h0, rr = 1'h0;
  logic                 rdy, done, awr, wr, bv, arr, rv;
  logic [7:0]           aw = 8'h00, ar = 8'h00, rdata;
  logic [3:0]           ws = 4'hF;
  logic [31:0]          wd = 32'h0, rd;
  logic [1:0]           bresp, rresp;
  acx_pkg::acx_inst_t   inst = 24'h0;
  acx_pkg::acx_rf_req_t req;
  int                   n_fail = 0, tests_run = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  acx_exec_unit u_acx_exec_unit (.mclk_i(clk), .rst_n_i(rst_n),
    .inst_valid_i(iv), .inst_i(inst), .inst_ready_o(rdy), .done_o(done),
    .rf_req_o(req), .rf_rdata_i(rdata), .s_axi_awaddr_i(aw),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr));
  acx_rf_model u_acx_rf_model (.mclk_i(clk), .rf_req_i(req),
    .rf_rdata_o(rdata));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    $display("CHECK FAILED handshake expected 1 seen 0");
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // handshakes are judged at the falling edge, where ready has settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ao, wo, bo;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    bo = 1'h0;
    for (int k = 0; k < 50 && !bo; k++) begin
      @(negedge clk);
      ao = awv && awr;
      wo = wv && wr;
      bo = bv;
      if (bo) chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (ao) awv <= 1'h0;
      if (wo) wv <= 1'h0;
    end
    br <= 1'h0;
    if (!bo) hang();
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e, input logic [1:0] er);
    logic ao, ro;
    @(posedge clk);
    ar <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    ro = 1'h0;
    for (int k = 0; k < 50 && !ro; k++) begin
      @(negedge clk);
      ao = arv && arr;
      ro = rv;
      if (ro) chk(nm, rd, e);
      if (ro) chk("rresp", {30'h0, rresp}, {30'h0, er});
      @(posedge clk);
      if (ao) arv <= 1'h0;
    end
    rr <= 1'h0;
    if (!ro) hang();
  endtask
  // returns at the falling edge of the write-back cycle when w is set
  task automatic exec(input logic [23:0] ins, input logic w);
    int k;
    @(posedge clk);
    inst <= ins;
    iv <= 1'h1;
    for (k = 0; k < 50 && !rdy; k++) @(negedge clk);
    @(posedge clk);
    iv <= 1'h0;
    if (k == 50) hang();
    for (k = 0; k < 20 && w && !done; k++) @(negedge clk);
    if (k == 20) hang();
  endtask
  task automatic adc(input logic [23:0] ins, input logic [5:0] fin,
                     input logic [7:0] da, ea, input logic [5:0] ef,
                     input logic [7:0] sa, sv);
    axw(8'h04, {26'h0, fin}, 2'h0);
    exec(ins, 1'h1);
    @(negedge clk);
    chk("result", u_acx_rf_model.mem[da], ea);
    chk("source", u_acx_rf_model.mem[sa], sv);
    rdchk("flags", 8'h04, {26'h0, ef}, 2'h0);
    rdchk("status", 8'h08, {16'h0, ea, 8'h0}, 2'h0);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) u_acx_rf_model.mem[i] = i[7:0] ^ 8'hA5;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    rdchk("flags_rst", 8'h04, 32'h0, 2'h0);
    rdchk("count_rst", 8'h0C, 32'h0, 2'h0);
    axw(8'h00, 32'h10, 2'h0);
    rdchk("ctrl", 8'h00, 32'h10, 2'h0);
    // byte 0 strobe off: the write is answered but must not land
    ws <= 4'hE;
    axw(8'h00, 32'h55, 2'h0);
    ws <= 4'hF;
    rdchk("ctrl_strb", 8'h00, 32'h10, 2'h0);
    u_acx_rf_model.mem[8'h13] = 8'h16;
    u_acx_rf_model.mem[8'h1B] = 8'h20;
    adc(24'h123B00, 6'h22, 8'h13, 8'h37, 6'h0, 8'h1B, 8'h20);
    u_acx_rf_model.mem[8'h1F] = 8'h16;
    u_acx_rf_model.mem[8'h1A] = 8'h20;
    u_acx_rf_model.mem[8'h20] = 8'h11;
    adc(24'h13FA00, 6'h02, 8'h1F, 8'h27, 6'h0, 8'h20, 8'h11);
    u_acx_rf_model.mem[8'h34] = 8'h2E;
    u_acx_rf_model.mem[8'h12] = 8'h1B;
    adc(24'h141234, 6'h22, 8'h34, 8'h4A, 6'h01, 8'h12, 8'h1B);
    u_acx_rf_model.mem[8'h4B] = 8'h82;
    u_acx_rf_model.mem[8'h13] = 8'h10;
    u_acx_rf_model.mem[8'h10] = 8'h01;
    adc(24'h15E34B, 6'h22, 8'h4B, 8'h84, 6'h08, 8'h10, 8'h01);
    u_acx_rf_model.mem[8'h6C] = 8'h2A;
    adc(24'h166C03, 6'h02, 8'h6C, 8'h2D, 6'h0, 8'h03, 8'hA6);
    exec(24'h166C03, 1'h1);
    exec(24'h166C03, 1'h1);
    @(negedge clk);
    chk("back_to_back", u_acx_rf_model.mem[8'h6C], 8'h33);
    u_acx_rf_model.mem[8'hD4] = 8'h5F;
    u_acx_rf_model.mem[8'h5F] = 8'h4C;
    adc(24'h17D402, 6'h22, 8'h5F, 8'h4F, 6'h0, 8'hD4, 8'h5F);
    u_acx_rf_model.mem[8'h40] = 8'hFF;
    adc(24'h164000, 6'h22, 8'h40, 8'h00, 6'h31, 8'h03, 8'hA6);
    u_acx_rf_model.mem[8'h15] = 8'h7F;
    adc(24'h16E500, 6'h22, 8'h15, 8'h80, 6'h0D, 8'h03, 8'hA6);
    u_acx_rf_model.mem[8'h41] = 8'h80;
    adc(24'h164180, 6'h02, 8'h41, 8'h00, 6'h34, 8'h03, 8'hA6);
    exec(24'h020000, 1'h0);
    rdchk("bad_op", 8'h08, 32'h2, 2'h0);
    axw(8'h08, 32'h2, 2'h0);
    rdchk("bad_clr", 8'h08, 32'h0, 2'h0);
    rdchk("count", 8'h0C, 32'h0B, 2'h0);
    rdchk("unmapped", 8'h10, 32'h0, 2'h2);
    axw(8'h10, 32'h5, 2'h2);
    test_done();
  end
endmodule
